// >>> design/usb_host_ctl.sv
// Purpose: host-side control of an embedded usb host: interrupt pin, bus state, resets, dma
// Assumes: pio pins and dma pins are asynchronous to core_clk and strobes last >= 3 clocks
// Notes:   register access is index on the command port then 16-bit data phases
// Operation
// R1: four interrupt pin modes, numbered zero to three
// R2: config bits select pin enable, edge, polarity
// R3: six usb events set sticky status bits
// R4: enabled usb events and master set summary
// R5: six cpu events combine into pin request
// R6: pin enable low freezes interrupt output
// R7: software clears status then drops pin enable
// R8: software clears enables then drops pin enable
// R9: four bus states in control bits 7:6
// R10: usb traffic only in running state
// R11: control reset bit forces bus reset state
// R12: pin reset and command A9 clear registers
// R13: software writes AA37 to B0 first
// R14: software sets both buffer lengths
// R15: software sets config, events, frame interval
// R16: software writes BA then B8 twice
// R17: dma request active high, acknowledge active low
// R18: dma moves half byte count, bursts
// R19: descriptor header eight bytes, word aligned
// R20: header bytes 0..3 field layout
// R21: header bytes 4..7 field layout
// R22: reserved header bits written zero
// R23: result codes zero to nine as listed
// R24: index then 16-bit phases, low first
// R25: counter end or external end stops dma
// R26: state codes reset resume running suspend
// R27: edge modes pulse once per new request
`timescale 1ns/1ps
`include "usb_host_ctl_defines.svh" // R19 R20 R21 R22 R23

module usb_host_ctl
    import usb_host_ctl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        cs_n,
    input  wire logic        a0,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe_n,
    input  wire logic [5:0]  usb_events,
    input  wire logic [4:0]  cpu_events,
    output logic             irq_out,
    output logic             traffic_en,
    output logic             dma_request,
    input  wire logic        dma_ack_n,
    input  wire logic        transfer_end
);

    // two-flop synchronisers; the second stage and its one-clock delayed copy are read
    logic [21:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg   <= 22'h3FFFFF;
            pin_s2_reg   <= 22'h3FFFFF;
            pin_prev_reg <= 22'h3FFFFF;
        end else begin
            pin_s1_reg   <= {cs_n, ~a0, rd_n, wr_n, dma_ack_n, ~transfer_end, data_in};
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    logic        cs_s, a0_s, rd_s, wr_s, ack_s, eot_s, rd_prev, wr_prev, ack_prev;
    logic [15:0] din_s;
    assign {cs_s, a0_s, rd_s, wr_s, ack_s} = ~pin_s2_reg[21:17];
    assign eot_s    = ~pin_s2_reg[16];
    assign din_s    = pin_s2_reg[15:0];
    assign rd_prev  = ~pin_prev_reg[19];
    assign wr_prev  = ~pin_prev_reg[18];
    assign ack_prev = ~pin_prev_reg[17];

    // act on the trailing edge of a strobe, when data and a0 are settled
    logic wr_done, rd_done, pio_sel;
    assign pio_sel = cs_s && !ack_s;
    assign wr_done = wr_prev && !wr_s && pio_sel;
    assign rd_done = rd_prev && !rd_s && pio_sel;

    // register file state
    logic [7:0]  index_reg, index_next;
    logic        phase_reg, phase_next;
    logic [31:0] control_reg, control_next, cmd_stat_reg, cmd_stat_next;
    logic [31:0] usb_st_reg, usb_st_next, usb_en_reg, usb_en_next;
    logic [31:0] fm_int_reg, fm_int_next;
    logic [15:0] hw_cfg_reg, hw_cfg_next, dma_cfg_reg, dma_cfg_next;
    logic [15:0] xfer_cnt_reg, xfer_cnt_next, cpu_st_reg, cpu_st_next;
    logic [15:0] cpu_en_reg, cpu_en_next, iso_len_reg, iso_len_next;
    logic [15:0] async_len_reg, async_len_next;
    logic [15:0] aux_one_reg, aux_one_next, aux_two_reg, aux_two_next;
    logic [15:0] aux_three_reg, aux_three_next, rdata_reg, rdata_next;
    logic        dma_stop;

    logic [5:0]  usb_hits;
    logic        usb_summary;
    assign usb_hits    = usb_st_reg[`EV_COUNT-1:0] & usb_en_reg[`EV_COUNT-1:0];
    assign usb_summary = (|usb_hits) && usb_en_reg[`USB_EV_MASTER_BIT]; // R4

    // merge one 16-bit phase into the low or high half of a 32-bit register
    function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                             input logic [15:0] val);
        put_half = hi ? {val, old[15:0]} : {old[31:16], val};
    endfunction : put_half

    logic [6:0]  ridx;
    logic        wsel;
    logic [31:0] rd_word;
    assign ridx = index_reg[6:0];
    assign wsel = wr_done && !a0_s && index_reg[`IDX_WRITE_BIT];

    always_comb begin
        index_next     = index_reg;
        phase_next     = phase_reg;
        control_next   = control_reg;
        cmd_stat_next  = cmd_stat_reg;
        usb_st_next    = usb_st_reg;
        usb_en_next    = usb_en_reg;
        fm_int_next    = fm_int_reg;
        hw_cfg_next    = hw_cfg_reg;
        dma_cfg_next   = dma_cfg_reg;
        xfer_cnt_next  = xfer_cnt_reg;
        cpu_st_next    = cpu_st_reg;
        cpu_en_next    = cpu_en_reg;
        iso_len_next   = iso_len_reg;
        async_len_next = async_len_reg;
        aux_one_next   = aux_one_reg;
        aux_two_next   = aux_two_reg;
        aux_three_next = aux_three_reg;
        rd_word        = `RESET_WORD32;
        unique case (ridx)
            `IDX_CONTROL:        rd_word = control_reg;
            `IDX_CMD_STATUS:     rd_word = cmd_stat_reg;
            `IDX_USB_EV_STATUS:  rd_word = usb_st_reg;
            `IDX_USB_EV_ENABLE:  rd_word = usb_en_reg;
            `IDX_FRAME_INTERVAL: rd_word = fm_int_reg;
            `IDX_HW_CONFIG:      rd_word = {16'h0000, hw_cfg_reg};
            `IDX_DMA_CONFIG:     rd_word = {16'h0000, dma_cfg_reg};
            `IDX_XFER_COUNT:     rd_word = {16'h0000, xfer_cnt_reg};
            `IDX_CPU_EV_STATUS:  rd_word = {16'h0000, cpu_st_reg};
            `IDX_CPU_EV_ENABLE:  rd_word = {16'h0000, cpu_en_reg};
            `IDX_ISO_BUF_LEN:    rd_word = {16'h0000, iso_len_reg};
            `IDX_ASYNC_BUF_LEN:  rd_word = {16'h0000, async_len_reg};
            default:             rd_word = `RESET_WORD32;
        endcase
        // write-index reads and unmapped indices return zero
        rdata_next = index_reg[`IDX_WRITE_BIT] ? `RESET_WORD16
                   : (phase_reg ? rd_word[31:16] : rd_word[15:0]); // R24
        if (wr_done && a0_s) begin
            index_next = din_s[7:0]; // R24
            phase_next = 1'b0;
        end else if (rd_done && !a0_s) begin
            phase_next = ~phase_reg; // R24
        end else if (wr_done && !a0_s) begin
            phase_next = ~phase_reg;
        end
        // usb and cpu event status bits are write-one-to-clear; command status is written directly
        if (wsel) begin
            unique case (index_reg)
                {1'b1, `IDX_CONTROL}:        control_next  = put_half(control_reg, phase_reg, din_s);
                {1'b1, `IDX_CMD_STATUS}:     cmd_stat_next = put_half(cmd_stat_reg, phase_reg, din_s);
                {1'b1, `IDX_USB_EV_STATUS}:  usb_st_next   = usb_st_reg & ~put_half(32'h0, phase_reg, din_s);
                {1'b1, `IDX_USB_EV_ENABLE}:  usb_en_next   = put_half(usb_en_reg, phase_reg, din_s);
                {1'b1, `IDX_FRAME_INTERVAL}: fm_int_next   = put_half(fm_int_reg, phase_reg, din_s);
                {1'b1, `IDX_HW_CONFIG}:      hw_cfg_next   = din_s; // R2
                {1'b1, `IDX_DMA_CONFIG}:     dma_cfg_next  = din_s;
                {1'b1, `IDX_XFER_COUNT}:     xfer_cnt_next = din_s;
                {1'b1, `IDX_CPU_EV_STATUS}:  cpu_st_next   = cpu_st_reg & ~din_s;
                {1'b1, `IDX_CPU_EV_ENABLE}:  cpu_en_next   = din_s;
                {1'b1, `IDX_ISO_BUF_LEN}:    iso_len_next  = din_s;
                {1'b1, `IDX_ASYNC_BUF_LEN}:  async_len_next = din_s;
                `CMD_AUX_ONE:                aux_one_next  = din_s;
                `CMD_AUX_TWO:                aux_two_next  = din_s;
                `CMD_AUX_THREE:              aux_three_next = din_s;
                default:                     control_next  = control_reg;
            endcase
        end
        // controller reset field drops the bus into reset, then self-clears
        if (cmd_stat_reg[`CMD_CTRL_RESET_BIT]) begin
            control_next[`CTRL_STATE_LSB +: 2] = state_bus_reset; // R11 R26
            cmd_stat_next[`CMD_CTRL_RESET_BIT] = 1'b0;
        end
        // hardware sets win over a same-cycle software clear
        usb_st_next[`EV_COUNT-1:0] = usb_st_next[`EV_COUNT-1:0] | usb_events; // R3
        cpu_st_next[`EV_COUNT-2:0] = cpu_st_next[`EV_COUNT-2:0] | cpu_events; // R5
        if (usb_summary) begin
            cpu_st_next[`CPU_EV_SUMMARY_BIT] = 1'b1; // R4
        end
        if (dma_stop) begin
            dma_cfg_next[`DMA_ENABLE_BIT] = 1'b0;
        end
    end

    // soft reset command clears the register file only, not the pin synchronisers, interrupt pin or dma counter
    logic soft_rst;
    assign soft_rst = wr_done && a0_s && (din_s[7:0] == `CMD_SOFT_RESET); // R12

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= 8'h00;  phase_reg <= 1'b0;
            control_reg <= `RESET_WORD32;  cmd_stat_reg <= `RESET_WORD32; // R12
            usb_st_reg <= `RESET_WORD32;   usb_en_reg <= `RESET_WORD32;
            fm_int_reg <= `RESET_WORD32;   hw_cfg_reg <= `RESET_WORD16;
            dma_cfg_reg <= `RESET_WORD16;  xfer_cnt_reg <= `RESET_WORD16;
            cpu_st_reg <= `RESET_WORD16;   cpu_en_reg <= `RESET_WORD16;
            iso_len_reg <= `RESET_WORD16;  async_len_reg <= `RESET_WORD16;
            aux_one_reg <= `RESET_WORD16;  aux_two_reg <= `RESET_WORD16;
            aux_three_reg <= `RESET_WORD16; rdata_reg <= `RESET_WORD16;
        end else if (soft_rst) begin
            index_reg <= 8'h00;  phase_reg <= 1'b0;
            control_reg <= `RESET_WORD32;  cmd_stat_reg <= `RESET_WORD32; // R12
            usb_st_reg <= `RESET_WORD32;   usb_en_reg <= `RESET_WORD32;
            fm_int_reg <= `RESET_WORD32;   hw_cfg_reg <= `RESET_WORD16;
            dma_cfg_reg <= `RESET_WORD16;  xfer_cnt_reg <= `RESET_WORD16;
            cpu_st_reg <= `RESET_WORD16;   cpu_en_reg <= `RESET_WORD16;
            iso_len_reg <= `RESET_WORD16;  async_len_reg <= `RESET_WORD16;
            aux_one_reg <= `RESET_WORD16;  aux_two_reg <= `RESET_WORD16;
            aux_three_reg <= `RESET_WORD16; rdata_reg <= `RESET_WORD16;
        end else begin
            index_reg <= index_next;        phase_reg <= phase_next;
            control_reg <= control_next;    cmd_stat_reg <= cmd_stat_next;
            usb_st_reg <= usb_st_next;      usb_en_reg <= usb_en_next;
            fm_int_reg <= fm_int_next;      hw_cfg_reg <= hw_cfg_next;
            dma_cfg_reg <= dma_cfg_next;    xfer_cnt_reg <= xfer_cnt_next;
            cpu_st_reg <= cpu_st_next;      cpu_en_reg <= cpu_en_next;
            iso_len_reg <= iso_len_next;    async_len_reg <= async_len_next;
            aux_one_reg <= aux_one_next;    aux_two_reg <= aux_two_next;
            aux_three_reg <= aux_three_next; rdata_reg <= rdata_next;
        end
    end

    assign data_out   = rdata_reg;
    assign data_oe_n  = !(cs_s && rd_s && !a0_s && !ack_s); // drives while oe_n low
    assign traffic_en = control_reg[`CTRL_STATE_LSB +: 2] == state_running; // R9 R10

    // interrupt pin: latched request, mode = {edge, polarity}
    logic cpu_req, latch_reg, latch_next, irq_reg, irq_next, pin_en, edge_m, pol_m;
    assign cpu_req = |(cpu_st_reg[`EV_COUNT-1:0] & cpu_en_reg[`EV_COUNT-1:0]); // R5
    assign pin_en  = hw_cfg_reg[`HW_PIN_EN_BIT];
    assign edge_m  = hw_cfg_reg[`HW_EDGE_BIT];
    assign pol_m   = hw_cfg_reg[`HW_POL_BIT];

    always_comb begin
        latch_next = pin_en ? cpu_req : latch_reg; // R6
        irq_next   = irq_reg;
        if (pin_en) begin
            // edge modes pulse for one clock per new request
            if (edge_m) begin
                irq_next = pol_m ? (cpu_req && !latch_reg) : !(cpu_req && !latch_reg); // R27
            end else begin
                irq_next = pol_m ? cpu_req : !cpu_req; // R1 R2
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_reg <= 1'b0;
            irq_reg   <= 1'b1;
        end else begin
            latch_reg <= latch_next;
            irq_reg   <= irq_next;
        end
    end
    assign irq_out = irq_reg;

    // dma word counter: half the byte count, bursts reopened by a fresh request
    dma_state_t  dma_state_reg, dma_state_next;
    logic [15:0] word_cnt_reg, word_cnt_next;
    logic [3:0]  burst_cnt_reg, burst_cnt_next;
    logic        word_done, count_hit;
    assign word_done = ack_s && ((rd_prev && !rd_s) || (wr_prev && !wr_s));
    assign count_hit = dma_cfg_reg[`DMA_COUNT_EN_BIT]
                       && (word_cnt_next == {1'b0, xfer_cnt_reg[15:1]}); // R18 R25
    assign dma_stop  = (dma_state_reg != dma_idle) && (count_hit || eot_s); // R25

    always_comb begin
        dma_state_next = dma_state_reg;
        word_cnt_next  = word_done ? word_cnt_reg + 16'h0001 : word_cnt_reg;
        burst_cnt_next = word_done ? burst_cnt_reg + 4'h1 : burst_cnt_reg;
        unique case (dma_state_reg)
            dma_idle: begin
                word_cnt_next  = 16'h0000;
                burst_cnt_next = 4'h0;
                if (dma_cfg_reg[`DMA_ENABLE_BIT]) dma_state_next = dma_req;
            end
            dma_req: begin
                if (dma_stop) dma_state_next = dma_idle;
                else if (word_done && burst_cnt_next > dma_cfg_reg[`DMA_BURST_LSB +: 4])
                    dma_state_next = dma_gap; // R18
            end
            dma_gap: begin
                burst_cnt_next = 4'h0;
                if (dma_stop) dma_state_next = dma_idle;
                else if (!ack_s && !ack_prev) dma_state_next = dma_req;
            end
            default: dma_state_next = dma_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_state_reg <= dma_idle;
            word_cnt_reg  <= 16'h0000;
            burst_cnt_reg <= 4'h0;
        end else begin
            dma_state_reg <= dma_state_next;
            word_cnt_reg  <= word_cnt_next;
            burst_cnt_reg <= burst_cnt_next;
        end
    end
    assign dma_request = dma_state_reg == dma_req; // R17

    // checks
    sequence new_request_s;
        pin_en && cpu_req && !latch_reg;
    endsequence
    chk_level_high_pin: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
        pin_en && !edge_m && pol_m |=> irq_out == $past(cpu_req))
        else $error("level high pin does not follow request");
    chk_edge_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_b) // R27
        new_request_s ##0 edge_m && pol_m ##1 pin_en && edge_m && pol_m |=> !irq_out)
        else $error("edge pulse longer than one clock");
    chk_frozen_pin_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // R6
        !pin_en |=> $stable(irq_out))
        else $error("interrupt pin moved while disabled");
    chk_summary_set_bit: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
        usb_summary && !soft_rst |=> cpu_st_reg[`CPU_EV_SUMMARY_BIT])
        else $error("summary bit not set");
    chk_event_sticky_set: assert property (@(posedge core_clk) disable iff (!rst_b) // R3
        usb_events[0] && !soft_rst |=> usb_st_reg[0])
        else $error("usb event lost");
    chk_traffic_state_map: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
        traffic_en |-> control_reg[7:6] == 2'h2)
        else $error("traffic outside running state");
    chk_ctrl_reset_bus: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        cmd_stat_reg[`CMD_CTRL_RESET_BIT] && !soft_rst |=> control_reg[7:6] == 2'h0)
        else $error("controller reset did not reach bus reset");
    chk_soft_reset_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
        soft_rst |=> hw_cfg_reg == 16'h0000 && cpu_en_reg == 16'h0000)
        else $error("soft reset left registers set");
    chk_dma_end_stop: assert property (@(posedge core_clk) disable iff (!rst_b) // R25
        dma_stop |=> !dma_request ##1 !dma_cfg_reg[`DMA_ENABLE_BIT] || dma_request)
        else $error("dma did not stop at end of transfer");

endmodule : usb_host_ctl

// >>> inc/usb_host_ctl_defines.svh
// Purpose: register indices, field positions and reset values of the host control block
// Assumes: 8-bit command indices, read index with bit 7 clear, write index with it set
// Notes:   descriptor header byte and bit positions are shared with software models
`ifndef USB_HOST_CTL_DEFINES_SVH
`define USB_HOST_CTL_DEFINES_SVH

`define IDX_WRITE_BIT       7
`define IDX_CONTROL         7'h01
`define IDX_CMD_STATUS      7'h02
`define IDX_USB_EV_STATUS   7'h03
`define IDX_USB_EV_ENABLE   7'h04
`define IDX_FRAME_INTERVAL  7'h0D
`define IDX_HW_CONFIG       7'h20
`define IDX_DMA_CONFIG      7'h21
`define IDX_XFER_COUNT      7'h22
`define IDX_CPU_EV_STATUS   7'h24
`define IDX_CPU_EV_ENABLE   7'h25
`define IDX_ISO_BUF_LEN     7'h2A
`define IDX_ASYNC_BUF_LEN   7'h2B
`define CMD_SOFT_RESET      8'hA9
`define CMD_AUX_ONE         8'hB0
`define CMD_AUX_THREE       8'hB8
`define CMD_AUX_TWO         8'hBA

`define HW_PIN_EN_BIT       0
`define HW_EDGE_BIT         1
`define HW_POL_BIT          2
`define CTRL_STATE_LSB      6
`define CMD_CTRL_RESET_BIT  0
`define USB_EV_MASTER_BIT   31
`define CPU_EV_SUMMARY_BIT  5
`define DMA_ENABLE_BIT      0
`define DMA_COUNT_EN_BIT    2
`define DMA_BURST_LSB       4

`define EV_COUNT            6
`define RESET_WORD16        16'h0000
`define RESET_WORD32        32'h0000_0000

`define HDR_BYTES           8
`define HDR_ALIGN_BYTES     4
`define FRAME_TIME_US       1000
`define HDR_RESULT_LSB      4
`define HDR_ACTIVE_BIT      3
`define HDR_TOGGLE_BIT      2
`define HDR_ENDPT_LSB       4
`define HDR_LAST_BIT        3
`define HDR_SPEED_BIT       2
`define HDR_FLAG_B5_BIT     5
`define HDR_TOKEN_LSB       2
`define HDR_FORMAT_BIT      7

`endif

// >>> inc/usb_host_ctl_pkg.sv
// Purpose: types shared by the host control block and its bench
// Assumes: constants come from the defines header
// Notes:   state codes follow the usual open host controller encoding
package usb_host_ctl_pkg;

    typedef enum logic [1:0] {
        state_bus_reset = 2'h0,
        state_waking    = 2'h1,
        state_running   = 2'h2,
        state_asleep    = 2'h3
    } func_state_t;

    typedef enum logic [3:0] {
        rc_no_error    = 4'h0,
        rc_crc         = 4'h1,
        rc_bit_stuff   = 4'h2,
        rc_toggle_bad  = 4'h3,
        rc_stall       = 4'h4,
        rc_no_response = 4'h5,
        rc_pid_check   = 4'h6,
        rc_pid_unexp   = 4'h7,
        rc_overrun     = 4'h8,
        rc_underrun    = 4'h9
    } result_code_t;

    typedef enum logic [2:0] {
        dma_idle = 3'b001,
        dma_req  = 3'b010,
        dma_gap  = 3'b100
    } dma_state_t;

endpackage : usb_host_ctl_pkg

// >>> tb/host_cpu_model.sv
// Purpose: host processor model driving the pio command and data ports
// Assumes: strobes 5 clocks low; select, a0, data held 2 clocks past them
// Notes:   a released data bus shows the inverse of the last word, never a stale copy
`timescale 1ns/1ps
module host_cpu_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] data_out,
    output logic             cs_n,
    output logic             a0,
    output logic             rd_n,
    output logic             wr_n,
    output logic [15:0]      data_in,
    output logic             dma_ack_n
);
    logic [15:0] rdata;

    // idle bus at time zero; dma acknowledge is active low, so held high
    initial begin
        cs_n      = 1'b1;
        a0        = 1'b1;
        rd_n      = 1'b1;
        wr_n      = 1'b1;
        data_in   = 16'h0000;
        dma_ack_n = 1'b1;
    end

    // one strobe; read data taken at the edge before release
    task automatic strobe(input logic port, input logic is_rd, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        cs_n    = 1'b0;
        a0      = port;
        data_in = d;
        rd_n    = ~is_rd;
        wr_n    = is_rd;
        repeat (5) @(posedge core_clk);
        rdata   = data_out;
        #1;
        rd_n    = 1'b1;
        wr_n    = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        cs_n    = 1'b1;
        data_in = ~d;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : strobe

    // index on the command port, then one data phase
    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d);
        strobe(1'b1, 1'b0, {8'h00, c});
        strobe(1'b0, 1'b0, d);
    endtask : wr_cmd

    // 32-bit write, low half first
    task automatic wr32(input logic [6:0] idx, input logic [31:0] d);
        strobe(1'b1, 1'b0, {8'h00, 1'b1, idx});
        strobe(1'b0, 1'b0, d[15:0]);
        strobe(1'b0, 1'b0, d[31:16]);
    endtask : wr32

    // two read phases; 16-bit registers use the low one only
    task automatic rd32(input logic [6:0] idx, output logic [31:0] d);
        strobe(1'b1, 1'b0, {9'h000, idx});
        strobe(1'b0, 1'b1, 16'h0000);
        d[15:0] = rdata;
        strobe(1'b0, 1'b1, 16'h0000);
        d[31:16] = rdata;
    endtask : rd32
endmodule : host_cpu_model

// >>> tb/usb_host_irq_state_descriptor_tb_top.sv
// Purpose: self-checking bench of the host control block
// Assumes: events are one-clock pulses; host model paces all strobes
// Notes:   dma covered for start and external stop only
`timescale 1ns/1ps
`include "usb_host_ctl_defines.svh"
module usb_host_irq_state_descriptor_tb_top
    import usb_host_ctl_pkg::*;
;
    logic        core_clk;
    logic        rst_b;
    logic        cs_n, a0, rd_n, wr_n, data_oe_n, irq_out;
    logic        traffic_en, dma_request, dma_ack_n, transfer_end;
    logic [15:0] data_in, data_out;
    logic [5:0]  usb_events;
    logic [4:0]  cpu_events;
    logic [31:0] rv, wv;
    logic [2:0]  cfg;
    int          errors, total_checks, seen, b;

    usb_host_ctl u_dut (.core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n), .a0(a0),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .usb_events(usb_events), .cpu_events(cpu_events),
        .irq_out(irq_out), .traffic_en(traffic_en), .dma_request(dma_request),
        .dma_ack_n(dma_ack_n), .transfer_end(transfer_end));
    host_cpu_model u_host (.core_clk(core_clk), .data_out(data_out), .cs_n(cs_n), .a0(a0),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .dma_ack_n(dma_ack_n));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {15'h0000, e}, {15'h0000, g});
    endtask : chk_bit

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // level modes show the request, edge modes rest inactive between pulses
    function automatic logic irq_exp(input logic [2:0] c, input logic act);
        return (act && !c[`HW_EDGE_BIT]) ? c[`HW_POL_BIT] : !c[`HW_POL_BIT];
    endfunction : irq_exp

    // one-clock event, then count cycles the pin is away from idle
    task automatic pulse(input logic to_usb, input int bit_i);
        @(posedge core_clk);
        #1;
        usb_events = to_usb ? 6'h01 << bit_i : 6'h00;
        cpu_events = to_usb ? 5'h00 : 5'h01 << bit_i;
        @(posedge core_clk);
        #1;
        usb_events = 6'h00;
        cpu_events = 5'h00;
        seen = 0;
        repeat (10) begin
            @(posedge core_clk);
            #1;
            seen += int'(irq_out !== irq_exp(cfg, 1'b0));
        end
    endtask : pulse

    // usb status first, else the summary sets again
    task automatic clear_all;
        u_host.wr32(`IDX_USB_EV_STATUS, 32'h0000_003F);
        u_host.wr_cmd({1'b1, `IDX_CPU_EV_STATUS}, 16'h003F);
    endtask : clear_all

    // hang guard, well past the run's length
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        print_verdict();
    end

    initial begin
        usb_events = 6'h00;
        cpu_events = 5'h00;
        transfer_end = 1'b0;
        rst_b = 1'b0;
        cfg = 3'h0;
        errors = 0;
        total_checks = 0;
        rv = $urandom(32'h7E90);
        repeat (2) @(posedge core_clk);
        #1 rst_b = 1'b1;
        chk_bit("irq_out reset", 1'b1, irq_out);
        chk_bit("traffic_en reset", 1'b0, traffic_en);
        u_host.wr_cmd(`CMD_AUX_ONE, 16'hAA37);
        wv = $urandom();
        u_host.wr_cmd({1'b1, `IDX_ISO_BUF_LEN}, wv[15:0]);
        u_host.wr_cmd({1'b1, `IDX_ASYNC_BUF_LEN}, wv[31:16]);
        u_host.rd32(`IDX_ISO_BUF_LEN, rv);
        chk_word("iso_buffer_length", wv[15:0], rv[15:0]);
        u_host.rd32(`IDX_ASYNC_BUF_LEN, rv);
        chk_word("async_buffer_length", wv[31:16], rv[15:0]);
        wv = $urandom();
        u_host.wr32(`IDX_FRAME_INTERVAL, wv);
        u_host.rd32(`IDX_FRAME_INTERVAL, rv);
        chk_word("frame_interval low", wv[15:0], rv[15:0]);
        chk_word("frame_interval high", wv[31:16], rv[31:16]);
        for (int s = 0; s < 4; s++) begin
            u_host.wr32(`IDX_CONTROL, 32'(s) << `CTRL_STATE_LSB);
            u_host.rd32(`IDX_CONTROL, rv);
            chk_word("func_state_field", 16'(s), {14'h0000, rv[7:6]});
            chk_bit("traffic_en", s == 2, traffic_en);
        end
        u_host.wr32(`IDX_CONTROL, 32'h0000_0080);
        u_host.wr_cmd(`CMD_AUX_TWO, 16'h2344);
        u_host.wr_cmd(`CMD_AUX_THREE, 16'h00A0);
        u_host.wr_cmd(`CMD_AUX_THREE, 16'h0080);
        u_host.wr32(`IDX_CMD_STATUS, 32'h0000_0001);
        u_host.rd32(`IDX_CONTROL, rv);
        chk_word("func_state_field", 16'h0000, {14'h0000, rv[7:6]});
        chk_bit("traffic_en", 1'b0, traffic_en);
        // all four pin modes; usb group for level, cpu group for edge
        for (int m = 0; m < 4; m++) begin
            cfg = {m[0], m[1], 1'b1};
            b = $urandom_range(4, 0);
            u_host.wr_cmd({1'b1, `IDX_HW_CONFIG}, {13'h0000, cfg});
            u_host.wr32(`IDX_USB_EV_ENABLE, {16'h8000, 16'h0001 << b});
            u_host.wr_cmd({1'b1, `IDX_CPU_EV_ENABLE}, 16'h0020 | (16'h0001 << b));
            clear_all();
            pulse(m < 2, b);
            if (m[1])
                chk_word("edge pulses", 16'h0001, 16'(seen));
            else
                chk_bit("irq level", irq_exp(cfg, 1'b1), irq_out);
            clear_all();
            chk_bit("irq idle", irq_exp(cfg, 1'b0), irq_out);
        end
        cfg = 3'h1;
        u_host.wr_cmd({1'b1, `IDX_HW_CONFIG}, 16'h0001);
        u_host.wr32(`IDX_USB_EV_ENABLE, 32'h0000_003F);
        pulse(1'b1, 0);
        chk_bit("irq without master", 1'b1, irq_out);
        u_host.wr32(`IDX_USB_EV_ENABLE, 32'h8000_003F);
        chk_bit("irq with master", 1'b0, irq_out);
        u_host.wr_cmd({1'b1, `IDX_HW_CONFIG}, 16'h0000);
        clear_all();
        chk_bit("irq frozen", 1'b0, irq_out);
        u_host.wr_cmd({1'b1, `IDX_HW_CONFIG}, 16'h0001);
        chk_bit("irq released", 1'b1, irq_out);
        u_host.strobe(1'b1, 1'b0, {8'h00, `CMD_SOFT_RESET});
        u_host.rd32(`IDX_FRAME_INTERVAL, rv);
        chk_word("frame_interval cleared", `RESET_WORD16, rv[15:0]);
        u_host.rd32(`IDX_HW_CONFIG, rv);
        chk_word("hardware_configuration cleared", `RESET_WORD16, rv[15:0]);
        u_host.wr_cmd({1'b1, `IDX_DMA_CONFIG}, 16'h0001);
        chk_bit("dma_request", 1'b1, dma_request);
        #1 transfer_end = 1'b1;
        repeat (6) @(posedge core_clk);
        #1 transfer_end = 1'b0;
        chk_bit("dma_request after end", 1'b0, dma_request);
        print_verdict();
    end
endmodule : usb_host_irq_state_descriptor_tb_top
